// [sma_defines.vh]
// System memory arbiter: register map, reset values and field layout.
// Assumes a plain register port with 3-bit word addresses and 8-bit data.
//
// Behaviour
// - High-ranked first peripheral stalls CPU on request
// - Lower second peripheral uses cycles first leaves
// - Unlocked: priorities writable, peripherals denied memory
// - Locked: priority writes ignored, peripherals get memory
// - Lock changes only right after unlock sequence
// - One-way option forbids clearing a set lock
// - Reset clears lock, allowing one more set
// - Only bits 2:0 implemented, rest read zero
// - Interrupt priority resets to 0
// - Main priority resets to 1
// - First DMA priority resets to 2
// - Second DMA priority resets to 3
// - Scanner priority resets to 4
// - Smaller value wins, 0 highest, 7 lowest
// - Low-ranked peripheral uses only idle CPU cycles
// - High-ranked peripheral holds CPU until done
`ifndef SMA_DEFINES_VH
`define SMA_DEFINES_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SMA_ADDR_ISR 3'h0
`define SMA_ADDR_MAIN 3'h1
`define SMA_ADDR_DMA1 3'h2
`define SMA_ADDR_DMA2 3'h3
`define SMA_ADDR_SCAN 3'h4
`define SMA_ADDR_LOCK 3'h5

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define SMA_PRI_W 3
`define SMA_PRI_MSB 2
`define SMA_LOCK_BIT 0
`define SMA_RST_ISR 3'h0
`define SMA_RST_MAIN 3'h1
`define SMA_RST_DMA1 3'h2
`define SMA_RST_DMA2 3'h3
`define SMA_RST_SCAN 3'h4

// ****************************************************************
// Unlock keys, requester slots and memory ports
// ****************************************************************
`define SMA_KEY_FIRST 8'h55
`define SMA_KEY_SECOND 8'hAA
`define SMA_NUM_REQ 5
`define SMA_NUM_PORT 3
`define SMA_PORT_PFM 0
`define SMA_PORT_DATA 1
`define SMA_PORT_EE 2

`endif

// [sma_unlock.v]
// Unlock sequence detector for the priority lock register.
// Assumes write strobes from the register port on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "sma_defines.vh"

module sma_unlock (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register write port
  input wire lock_wr,
  input wire other_wr,
  input wire [7:0] wdata,
  // Permission for the current lock write
  output wire commit
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_GOT_FIRST = 2'h1;
  localparam [1:0] ST_ARMED = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;

  assign commit = lock_wr && (state == ST_ARMED);

  // Next state; a stray write of any kind restarts the sequence
  always @* begin
    next_state = state;
    if (other_wr) begin
      next_state = ST_IDLE;
    end else if (lock_wr) begin
      case (state)
        ST_IDLE: begin
          if (wdata == `SMA_KEY_FIRST) begin
            next_state = ST_GOT_FIRST;
          end
        end
        ST_GOT_FIRST: begin
          if (wdata == `SMA_KEY_SECOND) begin
            next_state = ST_ARMED;
          end else begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// [sma_grant.v]
// Priority pick for one memory port among five requesters.
// Assumes requests and priorities are stable within the cycle.
`timescale 1ns/10ps
`default_nettype none
`include "sma_defines.vh"

module sma_grant (
  // Requests, slot 0 interrupt up to slot 4 scanner
  input wire [4:0] req,
  // Priority values, three bits per slot
  input wire [14:0] pri,
  // One-hot grant
  output reg [4:0] gnt
);

  integer i;
  integer j;
  reg beaten;

  always @* begin
    gnt = 5'h00;
    beaten = 1'b0;
    for (i = 0; i < `SMA_NUM_REQ; i = i + 1) begin
      beaten = 1'b0;
      for (j = 0; j < `SMA_NUM_REQ; j = j + 1) begin
        if (req[j] && (j != i)) begin
          if (pri[j*3 +: 3] < pri[i*3 +: 3]) begin
            beaten = 1'b1;
          end
          // Equal values fall back to slot order
          if ((pri[j*3 +: 3] == pri[i*3 +: 3]) && (j < i)) begin
            beaten = 1'b1;
          end
        end
      end
      gnt[i] = req[i] && !beaten;
    end
  end

endmodule
`default_nettype wire

// [sma_arbiter.v]
// System memory arbiter: priority registers, lock and per-port grant.
// Assumes all requesters run on clk and hold a request until granted
// and done; the one-way option is a static configuration level.
`timescale 1ns/10ps
`default_nettype none
`include "sma_defines.vh"

module sma_arbiter (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Configuration
  input wire lock_one_way,
  // Memory busy flags
  input wire pfm_busy,
  input wire ee_busy,
  // Requests, bit 0 program flash, 1 data space, 2 data EEPROM
  input wire [2:0] isr_req,
  input wire [2:0] main_req,
  input wire [2:0] dma_one_req,
  input wire [2:0] dma_two_req,
  input wire [2:0] scanner_req,
  // Grants, same bit order
  output wire [2:0] isr_gnt,
  output wire [2:0] main_gnt,
  output wire [2:0] dma_one_gnt,
  output wire [2:0] dma_two_gnt,
  output wire [2:0] scanner_gnt,
  // CPU hold and lock state
  output wire cpu_stall,
  output wire priorities_frozen
);

  // ****************************************************************
  // Priority and lock state
  // ****************************************************************

  reg [2:0] isr_priority;
  reg [2:0] main_priority;
  reg [2:0] dma_one_priority;
  reg [2:0] dma_two_priority;
  reg [2:0] scanner_priority;
  reg frozen;
  reg one_way_q;
  reg strap_taken;
  wire lock_wr;
  wire other_wr;
  wire commit;
  wire pri_wr;
  wire [14:0] pri_all;
  wire [2:0] peri_port_ok;
  wire [4:0] port_gnt [0:2];

  assign priorities_frozen = frozen;

  // Decode of write strobes
  assign lock_wr = reg_wr && (reg_addr == `SMA_ADDR_LOCK);
  assign other_wr = reg_wr && (reg_addr != `SMA_ADDR_LOCK);

  assign pri_wr = other_wr && !frozen;

  // Sequence detector for the lock register
  sma_unlock u_unlock (
    .clk(clk),
    .rst(rst),
    .lock_wr(lock_wr),
    .other_wr(other_wr),
    .wdata(reg_wdata),
    .commit(commit)
  );

  // One-way option caught after reset release, never under reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      one_way_q <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      one_way_q <= lock_one_way;
      strap_taken <= 1'b1;
    end
  end

  // Priority registers; the reset covers every reset type
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      isr_priority <= `SMA_RST_ISR;
      main_priority <= `SMA_RST_MAIN;
      dma_one_priority <= `SMA_RST_DMA1;
      dma_two_priority <= `SMA_RST_DMA2;
      scanner_priority <= `SMA_RST_SCAN;
    end else if (pri_wr) begin
      case (reg_addr)
        `SMA_ADDR_ISR: begin
          isr_priority <= reg_wdata[`SMA_PRI_MSB:0];
        end
        `SMA_ADDR_MAIN: begin
          main_priority <= reg_wdata[`SMA_PRI_MSB:0];
        end
        `SMA_ADDR_DMA1: begin
          dma_one_priority <= reg_wdata[`SMA_PRI_MSB:0];
        end
        `SMA_ADDR_DMA2: begin
          dma_two_priority <= reg_wdata[`SMA_PRI_MSB:0];
        end
        `SMA_ADDR_SCAN: begin
          scanner_priority <= reg_wdata[`SMA_PRI_MSB:0];
        end
        default: begin
          // Unmapped write is ignored
          isr_priority <= isr_priority;
        end
      endcase
    end
  end

  // Lock bit; the key writes themselves never touch it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      frozen <= 1'b0;
    end else if (commit) begin
      if (reg_wdata[`SMA_LOCK_BIT]) begin
        frozen <= 1'b1;
      end else if (!one_way_q) begin
        frozen <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register read back
  // ****************************************************************

  // Read data stand for one cycle only, zero otherwise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SMA_ADDR_ISR: begin
          reg_rdata <= {5'h00, isr_priority};
        end
        `SMA_ADDR_MAIN: begin
          reg_rdata <= {5'h00, main_priority};
        end
        `SMA_ADDR_DMA1: begin
          reg_rdata <= {5'h00, dma_one_priority};
        end
        `SMA_ADDR_DMA2: begin
          reg_rdata <= {5'h00, dma_two_priority};
        end
        `SMA_ADDR_SCAN: begin
          reg_rdata <= {5'h00, scanner_priority};
        end
        `SMA_ADDR_LOCK: begin
          reg_rdata <= {7'h00, frozen};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Grant per memory port
  // ****************************************************************

  // Packed priorities, slot order interrupt, main, DMA1, DMA2, scanner
  assign pri_all = {scanner_priority, dma_two_priority,
                    dma_one_priority, main_priority, isr_priority};

  // unlocked denies peripherals
  // A running flash or EEPROM operation keeps peripherals off that port
  assign peri_port_ok[`SMA_PORT_PFM] = frozen && !pfm_busy;
  assign peri_port_ok[`SMA_PORT_DATA] = frozen;
  assign peri_port_ok[`SMA_PORT_EE] = frozen && !ee_busy;

  genvar p;
  generate
    for (p = 0; p < `SMA_NUM_PORT; p = p + 1) begin : g_port
      wire [4:0] req_vec;
      assign req_vec = {scanner_req[p] && peri_port_ok[p],
                        dma_two_req[p] && peri_port_ok[p],
                        dma_one_req[p] && peri_port_ok[p],
                        main_req[p],
                        isr_req[p]};
      sma_grant u_grant (
        .req(req_vec),
        .pri(pri_all),
        .gnt(port_gnt[p])
      );
      assign isr_gnt[p] = port_gnt[p][0];
      assign main_gnt[p] = port_gnt[p][1];
      assign dma_one_gnt[p] = port_gnt[p][2];
      assign dma_two_gnt[p] = port_gnt[p][3];
      assign scanner_gnt[p] = port_gnt[p][4];
    end
  endgenerate

  // ****************************************************************
  // CPU stall
  // ****************************************************************

  // stall on any lost CPU request
  // The CPU waits whenever any port it asked for went elsewhere; it
  // keeps its request up, so it resumes as soon as the port frees.
  assign cpu_stall = |((isr_req & ~isr_gnt) | (main_req & ~main_gnt));

endmodule
`default_nettype wire

// [sma_checker.sv]
// Checker for the system memory arbiter, bound to its top module.
// Sees only the arbiter ports; one clock, reset active high.
`timescale 1ns/10ps
`default_nettype none
module sma_checker (
  // Clock, reset and register port
  input wire logic clk, rst, reg_wr, reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  // Configuration and status
  input wire logic lock_one_way, pfm_busy, ee_busy,
  input wire logic cpu_stall, priorities_frozen,
  // Requests and grants
  input wire logic [2:0] isr_req, main_req, dma_one_req, dma_two_req,
  input wire logic [2:0] scanner_req, isr_gnt, main_gnt, dma_one_gnt,
  input wire logic [2:0] dma_two_gnt, scanner_gnt
);
  // Peripheral grants merged per port, and per-port grant sets
  wire [2:0] per_gnt = dma_one_gnt | dma_two_gnt | scanner_gnt;
  wire [14:0] all_gnt = {isr_gnt, main_gnt, dma_one_gnt, dma_two_gnt,
    scanner_gnt};
  wire [14:0] all_req = {isr_req, main_req, dma_one_req, dma_two_req,
    scanner_req};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // Rules
  // ****************
  a_unlocked_denies: assert property (!priorities_frozen |-> !per_gnt)
    else $error("peripheral granted while unlocked");
  a_busy_gates: assert property (!(per_gnt & {ee_busy, 1'b0, pfm_busy}))
    else $error("peripheral granted on a busy memory");
  a_stall_cause: assert property (cpu_stall ==
    |((isr_req & ~isr_gnt) | (main_req & ~main_gnt)))
    else $error("stall does not match lost CPU requests");
  a_grant_needs_req: assert property (!(all_gnt & ~all_req))
    else $error("grant without request");
  a_one_winner: assert property ($onehot0(all_gnt & 15'h1249) &&
    $onehot0(all_gnt & 15'h2492) && $onehot0(all_gnt & 15'h4924))
    else $error("two grants on one port");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_read_width: assert property ($past(reg_rd) |-> !reg_rdata[7:3])
    else $error("unimplemented bits read as one");
  a_lock_read: assert property ($past(reg_rd && reg_addr == 3'h5) |->
    reg_rdata == {7'h00, $past(priorities_frozen)})
    else $error("lock read data wrong");
  a_lock_write_only: assert property ($changed(priorities_frozen) |->
    $past(reg_wr && reg_addr == 3'h5) &&
    priorities_frozen == $past(reg_wdata[0]))
    else $error("lock changed without a lock write");
  a_one_way_keeps: assert property ($fell(priorities_frozen) |->
    !lock_one_way)
    else $error("lock cleared under one-way option");
  c_stall: cover property (cpu_stall && per_gnt != 3'h0);
  c_lock: cover property ($rose(priorities_frozen));
  c_busy: cover property (ee_busy && scanner_req[2]);
endmodule
bind sma_arbiter sma_checker sma_checker_i (.clk, .rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .lock_one_way, .pfm_busy, .ee_busy,
  .cpu_stall, .priorities_frozen, .isr_req, .main_req, .dma_one_req,
  .dma_two_req, .scanner_req, .isr_gnt, .main_gnt, .dma_one_gnt,
  .dma_two_gnt, .scanner_gnt);
`default_nettype wire

// [sma_req_model.sv]
// Model of one peripheral memory client of the arbiter.
// Assumes grants come combinationally from the arbiter on clk.
`timescale 1ns/10ps
`default_nettype none
module sma_req_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Start pulse and wanted ports
  input wire logic start,
  input wire logic [2:0] want,
  // Arbiter side
  input wire logic [2:0] gnt,
  output logic [2:0] req,
  output logic done
);
  always @(posedge clk or posedge rst) begin
    if (rst)
      req <= 3'h0;
    else if (start)
      req <= want;
    else
      req <= req & ~gnt; // One granted cycle ends a port access
  end
  assign done = (req == 3'h0);
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the system memory arbiter.
// Drives the register port and requesters; one 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0;
  logic lock_one_way = 1'b0, pfm_busy = 1'b0, ee_busy = 1'b0;
  logic [2:0] reg_addr = 3'h0, isr_req = 3'h0, main_req = 3'h0;
  logic [2:0] dma_two_req = 3'h0, scanner_req = 3'h0, want = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [2:0] isr_gnt, main_gnt, dma_one_req, dma_one_gnt, dma_two_gnt;
  wire [2:0] scanner_gnt;
  wire cpu_stall, priorities_frozen, done;
  int miscompares = 0, samples_checked = 0;
  // Rows: {pfm busy, ee busy, isr, main, dma two, scanner requests}, then
  // {isr, main, dma two, scanner} grants and stall
  logic [13:0] row_in [7] = '{14'h0041, 14'h0051, 14'h06C0, 14'h0090,
    14'h1024, 14'h2041, 14'h0824};
  logic [12:0] row_out [7] = '{13'h003, 13'h023, 13'hC01, 13'h100,
    13'h000, 13'h080, 13'h009};
  always #50 clk = ~clk;
  sma_arbiter sma_arbiter_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .lock_one_way, .pfm_busy, .ee_busy, .isr_req,
    .main_req, .dma_one_req, .dma_two_req, .scanner_req, .isr_gnt,
    .main_gnt, .dma_one_gnt, .dma_two_gnt, .scanner_gnt, .cpu_stall,
    .priorities_frozen);
  sma_req_model sma_req_model_i (.clk, .rst, .start, .want,
    .gnt(dma_one_gnt), .req(dma_one_req), .done);
  // ****************
  // Tasks
  // ****************
  task automatic chk_reg(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_gnt(input string n, input logic [12:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_lock(input logic e);
    #1 chk_reg("priorities_frozen", {7'h00, e}, {7'h00, priorities_frozen});
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_reg("reg_rdata", e, reg_rdata);
  endtask
  task automatic unlock(input logic [7:0] d);
    wr(3'h5, 8'h55);
    wr(3'h5, 8'hAA);
    wr(3'h5, d);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 7; i++)
      rd(i[2:0], (i < 5) ? i[7:0] : 8'h00);
    @(posedge clk);
    scanner_req <= 3'h1;
    #1 chk_gnt("unlocked", 13'h000,
      {isr_gnt, main_gnt, dma_two_gnt, scanner_gnt, cpu_stall});
    scanner_req <= 3'h0;
    // Scanner first, then isr, main, dma one, dma two
    for (int i = 0; i < 5; i++)
      wr((i == 0) ? 3'h4 : i[2:0] - 3'h1, {5'h1F, i[2:0]});
    rd(3'h0, 8'h01);
    wr(3'h5, 8'h55);
    wr(3'h7, 8'h00);
    wr(3'h5, 8'hAA);
    wr(3'h5, 8'h01);
    chk_lock(1'b0);
    unlock(8'h01);
    chk_lock(1'b1);
    wr(3'h1, 8'h07);
    rd(3'h1, 8'h02);
    for (int r = 0; r < 7; r++) begin
      @(posedge clk);
      {pfm_busy, ee_busy, isr_req, main_req, dma_two_req, scanner_req}
        <= row_in[r];
      #1 chk_gnt("grants", row_out[r],
        {isr_gnt, main_gnt, dma_two_gnt, scanner_gnt, cpu_stall});
    end
    @(posedge clk);
    {pfm_busy, ee_busy, isr_req, dma_two_req, scanner_req} <= 11'h000;
    main_req <= 3'h2;
    start <= 1'b1;
    want <= 3'h2;
    @(posedge clk);
    start <= 1'b0;
    #1 chk_gnt("low peripheral", 13'h100,
      {isr_gnt, main_gnt, dma_two_gnt, dma_one_gnt, cpu_stall});
    main_req <= 3'h0;
    for (int k = 0; k < 20 && done !== 1'b1; k++)
      @(posedge clk);
    chk_reg("model done", 8'h01, {7'h00, done});
    if (done !== 1'b1)
      tally_and_finish();
    unlock(8'h00);
    chk_lock(1'b0);
    wr(3'h1, 8'h05);
    rd(3'h1, 8'h05);
    unlock(8'h01);
    lock_one_way <= 1'b1;
    do_reset();
    chk_lock(1'b0);
    // Equal values: the fixed slot order must favour the interrupt side
    wr(3'h1, 8'h00);
    @(posedge clk);
    {isr_req, main_req} <= 6'h09;
    #1 chk_gnt("tie", 13'h401,
      {isr_gnt, main_gnt, dma_two_gnt, scanner_gnt, cpu_stall});
    @(posedge clk);
    {isr_req, main_req} <= 6'h00;
    unlock(8'h01);
    chk_lock(1'b1);
    unlock(8'h00);
    chk_lock(1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
